//--- common/sfc_regs.svh
// Constants of the serial flash command front end.
// What this block does
// - frames start at select fall, MSB first
// - opcode sampled one bit per rising edge
// - opcode byte then address, data, output or nothing
// - read-type opcodes drive output data sequence
// - select rise stops driving, ends command
// - write-type executes only on byte boundary
// - partial program byte: no program, latch kept
// - 3Bh: address, dummy, dual-line stream
// - 6Bh: address, dummy, quad-line stream
// - 50h enables volatile status write
// - 92h: dual address, maker/part codes repeat
// - 48h: address, dummy, security stream
// - read address increments each output byte
// - write commands refused without write latch
// - status read repeats while clocking
// - busy flag high during status write cycle
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_OP_WREN     8'h06
`define SFC_OP_WRDI     8'h04
`define SFC_OP_RDST1    8'h05
`define SFC_OP_RDST2    8'h35
`define SFC_OP_RDST3    8'h15
`define SFC_OP_VWREN    8'h50
`define SFC_OP_WRST1    8'h01
`define SFC_OP_WRST2    8'h31
`define SFC_OP_WRST3    8'h11
`define SFC_OP_READ     8'h03
`define SFC_OP_FREAD    8'h0B
`define SFC_OP_DREAD    8'h3B
`define SFC_OP_QREAD    8'h6B
`define SFC_OP_PROG     8'h02
`define SFC_OP_SERASE   8'h20
`define SFC_OP_BERASE32 8'h52
`define SFC_OP_BERASE64 8'hD8
`define SFC_OP_CERASE1  8'hC7
`define SFC_OP_CERASE2  8'h60
`define SFC_OP_DSLEEP   8'hB9
`define SFC_OP_WAKE     8'hAB
`define SFC_OP_DUALID   8'h92
`define SFC_OP_SECERASE 8'h44
`define SFC_OP_SECPROG  8'h42
`define SFC_OP_SECREAD  8'h48
// status write self-timed cycle, in system clocks
`define SFC_WRST_CYCLES 16'h0100
`endif

//--- common/sfc_pkg.sv
// Types of the serial flash command front end.
package sfc_pkg;
   typedef enum logic [2:0] {
      SFC_ACT_NONE,
      SFC_ACT_PROG,
      SFC_ACT_ERASE,
      SFC_ACT_WRST,
      SFC_ACT_SECPROG,
      SFC_ACT_SECERASE,
      SFC_ACT_SLEEP
   } sfc_act_e;
   typedef struct packed {
      sfc_act_e    act;
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [7:0]  data;
      logic        volatileWr;
   } sfc_cmd_s;
endpackage

//--- rtl/sfc_front_end.sv
// Serial flash command decoder, link side on the serial clock.
`include "sfc_regs.svh"
module sfc_front_end
   import sfc_pkg::*;
(
   input  wire logic        clock,        // system clock
   input  wire logic        rst_n,        // reset, active low; sync in the system domain, async on the link record
   input  wire logic        sclk,         // host serial clock
   input  wire logic        csN,          // chip select, active low
   input  wire logic [3:0]  ioIn,         // io lines in
   output logic      [3:0]  ioOut,        // io lines out
   output logic      [3:0]  ioOeN,        // io enable, low drives
   output logic      [23:0] memAddr,      // array read address
   input  wire logic [7:0]  memData,      // array read data
   input  wire logic [7:0]  secData,      // security reg data
   input  wire logic [7:0]  statusByte1,  // status bits 7..0 w/o busy
   input  wire logic [7:0]  statusByte2,  // status bits 15..8
   input  wire logic [7:0]  statusByte3,  // status bits 23..16
   output sfc_cmd_s         cmdOut,       // executed command
   output logic             cmdValid,     // one-cycle command pulse
   output logic             writeEnableLatch, // write enable latch
   output logic             writeInProgressFlag // status write busy
);
   localparam logic [7:0] MAKER_CODE_BYTE = 8'hA5; // arbitrary value
   localparam logic [7:0] PART_CODE_BYTE  = 8'h5A; // arbitrary value

   typedef enum logic [2:0] {
      SFC_OPC, SFC_ADDR, SFC_DUMMY, SFC_DATA, SFC_OUT, SFC_IGNORE
   } sfc_st_e;

   function automatic logic isWriteOp(input logic [7:0] op);
      case (op)
         `SFC_OP_PROG, `SFC_OP_SERASE, `SFC_OP_BERASE32,
         `SFC_OP_BERASE64, `SFC_OP_CERASE1, `SFC_OP_CERASE2,
         `SFC_OP_WRST1, `SFC_OP_WRST2, `SFC_OP_WRST3,
         `SFC_OP_SECERASE, `SFC_OP_SECPROG: isWriteOp = 1'b1;
         default: isWriteOp = 1'b0;
      endcase
   endfunction

   // ---------------- serial clock domain ----------------
   // select high acts as the link reset: the serial clock stops between
   // frames, so each frame restarts from a clean state
   sfc_st_e     st_reg;
   logic [7:0]  op_reg;
   logic [23:0] addr_reg;
   logic [7:0]  sh_reg;
   logic [5:0]  cnt_reg;
   logic [2:0]  bitCnt_reg;
   logic [7:0]  data_reg;
   logic        byteOk_reg;
   logic        idSel_reg;
   logic [7:0]  opNext;
   logic        known;
   logic        addrOp;
   logic        dummyOp;
   logic        dataOp;
   logic        outOp;
   logic        dualOut;
   logic        quadOut;
   logic        dualIn;
   logic [2:0]  idxStep;

   assign opNext  = {op_reg[6:0], ioIn[0]};
   assign addrOp  = opNext inside {`SFC_OP_READ, `SFC_OP_FREAD,
      `SFC_OP_DREAD, `SFC_OP_QREAD, `SFC_OP_PROG, `SFC_OP_SERASE,
      `SFC_OP_BERASE32, `SFC_OP_BERASE64, `SFC_OP_DUALID,
      `SFC_OP_SECERASE, `SFC_OP_SECPROG, `SFC_OP_SECREAD};
   assign dataOp  = opNext inside {`SFC_OP_PROG, `SFC_OP_WRST1,
      `SFC_OP_WRST2, `SFC_OP_WRST3, `SFC_OP_SECPROG};
   assign outOp   = opNext inside {`SFC_OP_RDST1, `SFC_OP_RDST2,
      `SFC_OP_RDST3, `SFC_OP_WAKE};
   assign known   = addrOp | dataOp | outOp | opNext inside {
      `SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_VWREN, `SFC_OP_CERASE1,
      `SFC_OP_CERASE2, `SFC_OP_DSLEEP};
   assign dummyOp = op_reg inside {`SFC_OP_FREAD, `SFC_OP_DREAD,
      `SFC_OP_QREAD, `SFC_OP_SECREAD, `SFC_OP_DUALID};
   assign dualOut = op_reg == `SFC_OP_DREAD || op_reg == `SFC_OP_DUALID;
   assign quadOut = op_reg == `SFC_OP_QREAD;
   assign dualIn  = op_reg == `SFC_OP_DUALID;
   // bits per edge: 1, 2 (dual) or 4 (quad)
   assign idxStep = quadOut ? 3'd4 : (dualOut ? 3'd2 : 3'd1);

   logic [7:0] outByte;
   assign outByte =
      op_reg == `SFC_OP_RDST1   ? {statusByte1[7:1], writeInProgressFlag} :
      op_reg == `SFC_OP_RDST2   ? statusByte2 :
      op_reg == `SFC_OP_RDST3   ? statusByte3 :
      op_reg == `SFC_OP_WAKE    ? PART_CODE_BYTE :
      op_reg == `SFC_OP_SECREAD ? secData :
      op_reg == `SFC_OP_DUALID  ? (idSel_reg ? PART_CODE_BYTE :
                                   MAKER_CODE_BYTE) :
      memData;

   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         st_reg     <= SFC_OPC;
         op_reg     <= 8'h00;
         addr_reg   <= 24'h000000;
         sh_reg     <= 8'h00;
         cnt_reg    <= 6'h00;
         bitCnt_reg <= 3'h0;
         data_reg   <= 8'h00;
         byteOk_reg <= 1'b1;
         idSel_reg  <= 1'b0;
      end else begin
         bitCnt_reg <= bitCnt_reg + 3'h1;
         byteOk_reg <= bitCnt_reg == 3'h7;
         unique case (st_reg)
            SFC_OPC: begin
               op_reg  <= opNext;
               cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg == 6'h07) begin
                  cnt_reg <= 6'h00;
                  st_reg  <= !known ? SFC_IGNORE : addrOp ? SFC_ADDR :
                             dataOp ? SFC_DATA :
                             outOp ? SFC_OUT : SFC_IGNORE;
               end
            end
            SFC_ADDR: begin
               addr_reg <= dualIn ? {addr_reg[21:0], ioIn[1:0]}
                                  : {addr_reg[22:0], ioIn[0]};
               cnt_reg  <= cnt_reg + 6'h01;
               if (cnt_reg == (dualIn ? 6'h0B : 6'h17)) begin
                  cnt_reg <= 6'h00;
                  st_reg  <= dummyOp ? SFC_DUMMY :
                             isWriteOp(op_reg) && op_reg != `SFC_OP_PROG &&
                             op_reg != `SFC_OP_SECPROG ? SFC_IGNORE :
                             (op_reg == `SFC_OP_PROG ||
                              op_reg == `SFC_OP_SECPROG) ? SFC_DATA :
                             SFC_OUT;
               end
            end
            SFC_DUMMY: begin
               cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg == (dualIn ? 6'h03 : 6'h07)) begin
                  cnt_reg <= 6'h00;
                  st_reg  <= SFC_OUT;
               end
            end
            SFC_DATA: begin
               sh_reg <= {sh_reg[6:0], ioIn[0]};
               if (bitCnt_reg == 3'h7) begin
                  data_reg <= {sh_reg[6:0], ioIn[0]};
               end
            end
            SFC_OUT: begin
               cnt_reg <= cnt_reg + {3'h0, idxStep};
               if (cnt_reg + {3'h0, idxStep} >= 6'h08) begin
                  cnt_reg  <= 6'h00;
                  idSel_reg <= ~idSel_reg;
                  if (op_reg != `SFC_OP_RDST1 && op_reg != `SFC_OP_RDST2
                      && op_reg != `SFC_OP_RDST3) begin
                     addr_reg <= addr_reg + 24'h000001;
                  end
               end
            end
            SFC_IGNORE: begin
               op_reg <= op_reg;
            end
         endcase
      end
   end

   // output shifts on the falling edge, bit index counts from msb
   logic [3:0] ioOut_reg;
   logic [3:0] ioOeN_reg;
   logic [2:0] hi;
   assign hi = 3'h7 - cnt_reg[2:0];
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         ioOut_reg <= 4'h0;
         ioOeN_reg <= 4'hF;
      end else if (st_reg == SFC_OUT) begin
         if (quadOut) begin
            ioOut_reg <= cnt_reg[2] ? outByte[3:0] : outByte[7:4];
            ioOeN_reg <= 4'h0;
         end else if (dualOut) begin
            ioOut_reg <= {2'b00, outByte[hi], outByte[hi - 3'h1]};
            ioOeN_reg <= 4'hC;
         end else begin
            ioOut_reg <= {2'b00, outByte[hi], 1'b0};
            ioOeN_reg <= 4'hD;
         end
      end else begin
         ioOut_reg <= 4'h0;
         ioOeN_reg <= 4'hF;
      end
   end
   assign ioOut   = ioOut_reg;
   assign ioOeN   = ioOeN_reg;
   assign memAddr = addr_reg;

   // end-of-frame record, taken at select rise and toggled across
   sfc_cmd_s lnkCmd_reg;
   logic     lnkTog_reg;
   logic     lnkOk;
   assign lnkOk = byteOk_reg && st_reg != SFC_IGNORE &&
                  !(st_reg == SFC_OPC) && !(st_reg == SFC_ADDR);
   // toggle needs a known start, else the far side never sees an edge
   always_ff @(posedge csN or negedge rst_n) begin
      if (!rst_n) begin
         lnkCmd_reg <= '0;
         lnkTog_reg <= 1'b0;
      end else begin
         lnkCmd_reg.opcode     <= op_reg;
         lnkCmd_reg.addr       <= addr_reg;
         lnkCmd_reg.data       <= data_reg;
         lnkCmd_reg.volatileWr <= 1'b0;
         lnkCmd_reg.act        <= SFC_ACT_NONE;
         lnkTog_reg            <= ~lnkTog_reg;
         if (lnkOk || (byteOk_reg && st_reg == SFC_IGNORE)) begin
            lnkCmd_reg.act <= SFC_ACT_SLEEP;
         end
      end
   end
   logic lnkValid_reg;
   always_ff @(posedge csN) begin
      lnkValid_reg <= byteOk_reg && (st_reg == SFC_DATA ||
         (st_reg == SFC_IGNORE && op_reg inside {`SFC_OP_WREN,
         `SFC_OP_WRDI, `SFC_OP_VWREN, `SFC_OP_CERASE1, `SFC_OP_CERASE2,
         `SFC_OP_DSLEEP, `SFC_OP_SERASE, `SFC_OP_BERASE32,
         `SFC_OP_BERASE64, `SFC_OP_SECERASE}));
   end

   // ---------------- system clock domain ----------------
   logic [2:0]  togSync_reg;
   sfc_cmd_s    cmd_reg;
   logic        valid_reg;
   logic        wel_reg;
   logic        volEn_reg;
   logic [15:0] busy_reg;
   logic        evt;
   logic [7:0]  eop;
   logic        exec;
   logic        needWel;
   assign evt     = togSync_reg[2] ^ togSync_reg[1];
   assign eop     = lnkCmd_reg.opcode;
   assign needWel = isWriteOp(eop);
   assign exec    = evt && lnkValid_reg && !(needWel && !wel_reg)
                    && busy_reg == 16'h0000;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         togSync_reg <= 3'b000;
         cmd_reg     <= '0;
         valid_reg   <= 1'b0;
         wel_reg     <= 1'b0;
         volEn_reg   <= 1'b0;
         busy_reg    <= 16'h0000;
      end else begin
         togSync_reg <= {togSync_reg[1:0], lnkTog_reg};
         valid_reg   <= exec && eop != `SFC_OP_WREN &&
                        eop != `SFC_OP_WRDI && eop != `SFC_OP_VWREN;
         if (busy_reg != 16'h0000) begin
            busy_reg <= busy_reg - 16'h0001;
            if (busy_reg == 16'h0001) begin
               wel_reg <= 1'b0;
            end
         end
         if (exec) begin
            cmd_reg            <= lnkCmd_reg;
            cmd_reg.volatileWr <= volEn_reg;
            unique case (eop)
               `SFC_OP_WREN:  wel_reg   <= 1'b1;
               `SFC_OP_WRDI:  wel_reg   <= 1'b0;
               `SFC_OP_VWREN: volEn_reg <= 1'b1;
               `SFC_OP_WRST1, `SFC_OP_WRST2, `SFC_OP_WRST3: begin
                  busy_reg  <= `SFC_WRST_CYCLES;
                  volEn_reg <= 1'b0;
                  cmd_reg.act <= SFC_ACT_WRST;
               end
               `SFC_OP_PROG: begin
                  wel_reg <= 1'b0;
                  cmd_reg.act <= SFC_ACT_PROG;
               end
               `SFC_OP_SECPROG: begin
                  wel_reg <= 1'b0;
                  cmd_reg.act <= SFC_ACT_SECPROG;
               end
               `SFC_OP_SECERASE: begin
                  wel_reg <= 1'b0;
                  cmd_reg.act <= SFC_ACT_SECERASE;
               end
               `SFC_OP_DSLEEP: cmd_reg.act <= SFC_ACT_SLEEP;
               default: begin
                  wel_reg <= 1'b0;
                  cmd_reg.act <= SFC_ACT_ERASE;
               end
            endcase
         end
      end
   end
   assign cmdOut              = cmd_reg;
   assign cmdValid            = valid_reg;
   assign writeEnableLatch    = wel_reg;
   assign writeInProgressFlag = busy_reg != 16'h0000;

   AST_BUSY_START: assert property (@(posedge clock) disable iff (!rst_n)
      exec && eop == `SFC_OP_WRST1 |=> writeInProgressFlag)
      else $error("busy flag not set after status write");
   AST_REFUSE: assert property (@(posedge clock) disable iff (!rst_n)
      exec && needWel |-> wel_reg)
      else $error("write command executed without latch");
   AST_WREN: assert property (@(posedge clock) disable iff (!rst_n)
      exec && eop == `SFC_OP_WREN |=> writeEnableLatch)
      else $error("write enable not latched");
   AST_BUSY_END: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(writeInProgressFlag) |-> !writeEnableLatch)
      else $error("latch not cleared at end of status write");
   AST_NO_DRIVE: assert property (@(posedge clock)
      csN |-> ##2 ioOeN == 4'hF)
      else $error("io driven with select high");
   AST_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      cmdValid |=> !cmdValid)
      else $error("command pulse longer than one cycle");
   AST_VOL: assert property (@(posedge clock) disable iff (!rst_n)
      exec && eop == `SFC_OP_VWREN |=> volEn_reg && $stable(wel_reg))
      else $error("volatile enable touched latch");
   AST_IGN: assert property (@(negedge sclk) disable iff (csN)
      st_reg == SFC_IGNORE |-> ioOeN_reg == 4'hF)
      else $error("ignored frame drives io");
endmodule

//--- tb/sfc_host_model.sv
// Host controller model that frames commands on the serial flash link.
module sfc_host_model (
   output logic       sclk,  // serial clock, still outside frames
   output logic       csN,   // chip select, active low
   output wire  [3:0] ioIn,  // resolved io lines
   input  wire  [3:0] ioOut, // device io out
   input  wire  [3:0] ioOeN  // device io enable, low drives
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] hostVal;
   logic       hostDrv;
   logic [3:0] junk;
   // undriven lines toggle so a stale value never passes for data
   assign ioIn = (~ioOeN & ioOut) | (ioOeN & (hostDrv ? hostVal : junk));
   initial begin
      sclk = 1'b0;
      csN = 1'b0;
      hostVal = 4'h0;
      hostDrv = 1'b0;
      junk = 4'h5;
      // a real rising select edge clears the link logic at start
      #1 csN = 1'b1;
   end
   task automatic startFrame();
      csN = 1'b0;
      hostDrv = 1'b1;
      #5;
   endtask
   task automatic pulse();
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
      junk = ~junk;
   endtask
   task automatic sendBits(input logic [23:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         hostVal = {3'b000, v[i]};
         pulse();
      end
   endtask
   task automatic getByte(input int lanes, output logic [7:0] b);
      hostDrv = 1'b0;
      b = 8'h00;
      for (int i = 0; i < 8 / lanes; i++) begin
         #6 sclk = 1'b1;
         case (lanes)
            1: b = {b[6:0], ioIn[1]};
            2: b = {b[5:0], ioIn[1:0]};
            default: b = {b[3:0], ioIn};
         endcase
         #6 sclk = 1'b0;
         junk = ~junk;
      end
   endtask
   task automatic endFrame();
      #3 csN = 1'b1;
      hostDrv = 1'b0;
      #40;
   endtask
endmodule

//--- tb/serial_flash_command_front_end_bench.sv
// Self-checking bench of the serial flash command front end.
`include "sfc_regs.svh"
module serial_flash_command_front_end_bench
   import sfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  stat1 = 8'hA4;
   wire         sclk, csN, cmdValid, write_enable_latch, write_in_progress_flag;
   wire  [3:0]  ioIn, ioOut, ioOeN;
   wire  [23:0] memAddr;
   // array models: contents follow the address
   wire  [7:0]  memData = memAddr[7:0] + 8'h11;
   wire  [7:0]  secData = ~memAddr[7:0];
   sfc_cmd_s    cmdOut, lastCmd;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cmdCnt = 0;
   int          cycles = 0;
   logic [7:0]  b;
   initial begin
      forever #4 clock = ~clock;
   end
   sfc_host_model H (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
      .ioOeN(ioOeN));
   sfc_front_end DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk), .csN(csN),
      .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .memAddr(memAddr),
      .memData(memData), .secData(secData), .statusByte1(stat1),
      .statusByte2(8'h5C), .statusByte3(8'h3A), .cmdOut(cmdOut),
      .cmdValid(cmdValid), .writeEnableLatch(write_enable_latch),
      .writeInProgressFlag(write_in_progress_flag));
   always @(posedge clock) begin
      if (cmdValid === 1'b1) begin
         cmdCnt <= cmdCnt + 1;
         lastCmd <= cmdOut;
      end
   end
   task automatic end_sim();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard, runs well above the full sequence
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] v);
      H.startFrame();
      H.sendBits({16'h0000, op}, 8);
      if (n > 0) begin
         H.sendBits(v, n);
      end
      H.endFrame();
      repeat (4) @(posedge clock);
   endtask
   task automatic t_latch();
      int n;
      cmd(`SFC_OP_WREN, 0, 0);
      chk(write_enable_latch, 1);
      cmd(`SFC_OP_WRDI, 0, 0);
      chk(write_enable_latch, 0);
      n = cmdCnt;
      cmd(`SFC_OP_SERASE, 24, 24'h012345);
      chk(cmdCnt, n);
      cmd(`SFC_OP_WREN, 0, 0);
      cmd(`SFC_OP_SERASE, 24, 24'h012345);
      chk(cmdCnt, n + 1);
      chk(lastCmd.act, SFC_ACT_ERASE);
      chk(lastCmd.addr, 24'h012345);
   endtask
   task automatic t_partial();
      int n;
      cmd(`SFC_OP_WREN, 0, 0);
      n = cmdCnt;
      H.startFrame();
      H.sendBits({16'h0000, `SFC_OP_SERASE}, 8);
      H.sendBits(24'h000100, 24);
      H.sendBits(24'h000001, 1);
      H.endFrame();
      H.startFrame();
      H.sendBits({16'h0000, `SFC_OP_PROG}, 8);
      H.sendBits(24'h000200, 24);
      H.sendBits(24'h00003C, 8);
      H.sendBits(24'h000005, 3);
      H.endFrame();
      repeat (4) @(posedge clock);
      chk(cmdCnt, n);
      chk(write_enable_latch, 1);
   endtask
   task automatic t_reads();
      logic [7:0]  op [5] = '{`SFC_OP_READ, `SFC_OP_FREAD, `SFC_OP_DREAD,
                              `SFC_OP_QREAD, `SFC_OP_SECREAD};
      int          ln [5] = '{1, 1, 2, 4, 1};
      logic [23:0] a;
      logic [7:0]  e;
      for (int k = 0; k < 5; k++) begin
         a = 24'h0000F0 + 24'(k * 16);
         H.startFrame();
         H.sendBits({16'h0000, op[k]}, 8);
         H.sendBits(a, 24);
         if (k > 0) begin
            H.sendBits(24'h000000, 8);
         end
         for (int j = 0; j < 2; j++) begin
            H.getByte(ln[k], b);
            e = a[7:0] + j[7:0];
            chk(8'(k == 4 ? ~e : e + 8'h11), b);
         end
         H.endFrame();
         chk(ioOeN, 4'hF);
      end
   endtask
   task automatic t_dualid();
      H.startFrame();
      H.sendBits({16'h0000, `SFC_OP_DUALID}, 8);
      H.sendBits(24'h000000, 16);
      H.getByte(2, b);
      chk(b, 8'hA5);
      H.getByte(2, b);
      chk(b, 8'h5A);
      H.getByte(2, b);
      chk(b, 8'hA5);
      H.endFrame();
   endtask
   task automatic t_abort();
      H.startFrame();
      H.sendBits({16'h0000, `SFC_OP_READ}, 8);
      H.sendBits(24'h000300, 24);
      repeat (3) H.pulse();
      chk(ioOeN, 4'hD);
      H.endFrame();
      chk(ioOeN, 4'hF);
      cmd(`SFC_OP_WRDI, 0, 0);
      chk(write_enable_latch, 0);
   endtask
   task automatic t_unknown();
      int n;
      n = cmdCnt;
      H.startFrame();
      H.sendBits(24'h0000FF, 8);
      H.sendBits({16'h0000, `SFC_OP_WREN}, 8);
      chk(ioOeN, 4'hF);
      H.endFrame();
      repeat (4) @(posedge clock);
      chk(write_enable_latch, 0);
      chk(cmdCnt, n);
   endtask
   task automatic rdStatus(input logic [7:0] exp);
      H.startFrame();
      H.sendBits({16'h0000, `SFC_OP_RDST1}, 8);
      for (int j = 0; j < 2; j++) begin
         H.getByte(1, b);
         chk(b, exp);
      end
      H.endFrame();
   endtask
   task automatic t_status();
      rdStatus(8'hA4);
      cmd(`SFC_OP_WREN, 0, 0);
      cmd(`SFC_OP_WRST1, 8, 24'h00003C);
      chk(write_in_progress_flag, 1);
      chk(lastCmd.act, SFC_ACT_WRST);
      rdStatus(8'hA5);
      repeat (300) @(posedge clock);
      chk(write_in_progress_flag, 0);
      cmd(`SFC_OP_WREN, 0, 0);
      cmd(`SFC_OP_VWREN, 0, 0);
      cmd(`SFC_OP_WRST1, 8, 24'h0000C3);
      chk(lastCmd.volatileWr, 1);
      chk(lastCmd.data, 8'hC3);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_latch();
      t_partial();
      t_reads();
      t_dualid();
      t_abort();
      t_unknown();
      t_status();
      end_sim();
   end
endmodule
